// file: rtl/dsc_sram_host.sv
// module: host controller driving an 8K x 8 dual-select static memory
`timescale 1ns/100ps
module dsc_sram_host
  import dsc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              arst_n,
  // user request side
  input  wire logic              reqValid,
  output logic                   reqReady,
  input  wire logic              reqWrite,
  input  wire logic [ADDR_W-1:0] reqAddr,
  input  wire logic [DATA_W-1:0] reqData,
  output logic                   rspValid,
  output logic [DATA_W-1:0]      rspData,
  // memory pins
  output logic [ADDR_W-1:0]      wordSelectLines,
  output logic                   selectPrimaryN,
  output logic                   selectSecondaryHi,
  output logic                   outEnableN,
  output logic                   writeStrobeN,
  input  wire logic [DATA_W-1:0] byteLanesIn,
  output logic [DATA_W-1:0]      byteLanesOut,
  output logic                   byteLanesOe
);
  // ---------------------------------------------------------------
  // state and timer
  // ---------------------------------------------------------------
  dsc_state_e state_ff;
  dsc_state_e nxt_state;
  logic       isWrite_ff;
  logic [DATA_W-1:0] rdSync1_ff;
  logic [DATA_W-1:0] rdSync2_ff;
  logic [DATA_W-1:0] rdSync3_ff;
  dsc_timer_if tif ();

  dsc_timer u_timer (
    .clk    (clk),
    .arst_n (arst_n),
    .tif    (tif)
  );

  assign reqReady = (state_ff == DSC_IDLE);
  logic accept;
  assign accept = reqValid && reqReady;

  always_comb begin
    nxt_state = state_ff;
    tif.load  = 1'b0;
    tif.count = CNT_ZERO;
    unique case (state_ff)
      DSC_IDLE: begin
        if (accept) begin
          nxt_state = DSC_SETUP;
          tif.load  = 1'b1;
          tif.count = CNT_ONE;
        end
      end
      DSC_SETUP: begin
        if (tif.done) begin
          nxt_state = isWrite_ff ? DSC_WRITE : DSC_READ;
          tif.load  = 1'b1;
          // read stretched so the synced sample postdates access time
          tif.count = isWrite_ff ? WP_CYC : 4'(RD_CYC + SYNC_CYC);
        end
      end
      DSC_READ, DSC_WRITE: begin
        if (tif.done) begin
          nxt_state = DSC_REC;
          tif.load  = 1'b1;
          tif.count = isWrite_ff ? REC_CYC : TURN_CYC;
        end
      end
      DSC_REC: begin
        if (tif.done) begin
          nxt_state = DSC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= DSC_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ---------------------------------------------------------------
  // captured request
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      isWrite_ff      <= 1'b0;
      wordSelectLines <= '0;
      byteLanesOut    <= '0;
    end else if (accept) begin
      isWrite_ff      <= reqWrite;
      wordSelectLines <= reqAddr;
      byteLanesOut    <= reqData;
    end
  end

  // ---------------------------------------------------------------
  // pin sequencing
  // ---------------------------------------------------------------
  // both selects move together so either can terminate a write
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      selectPrimaryN    <= 1'b1;
      selectSecondaryHi <= 1'b0;
    end else begin
      selectPrimaryN    <= !(nxt_state inside {DSC_READ, DSC_WRITE});
      selectSecondaryHi <= (nxt_state inside {DSC_READ, DSC_WRITE});
    end
  end

  // strobe falls with the selects; address set a cycle earlier
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      writeStrobeN <= 1'b1;
    end else begin
      writeStrobeN <= !(nxt_state == DSC_WRITE);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      outEnableN <= 1'b1;
    end else begin
      outEnableN <= !(nxt_state == DSC_READ);
    end
  end

  // data driven only while writing; recovery gap keeps the
  // memory's output turn-off clear of our drive
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      byteLanesOe <= 1'b0;
    end else begin
      // keyed on this request only; a stale write flag must not
      // drive the lanes during a read's setup
      byteLanesOe <= (accept && reqWrite) ||
                     (nxt_state == DSC_WRITE);
    end
  end

  // ---------------------------------------------------------------
  // read data capture
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdSync1_ff <= '0;
      rdSync2_ff <= '0;
      rdSync3_ff <= '0;
    end else begin
      rdSync1_ff <= byteLanesIn;
      rdSync2_ff <= rdSync1_ff;
      rdSync3_ff <= rdSync2_ff;
    end
  end

  // sample at end of read; the stretch above keeps the second flop's
  // sample later than the access time; the third flop's is taken only when it matches
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rspValid <= 1'b0;
      rspData  <= '0;
    end else begin
      rspValid <= (state_ff == DSC_READ) && tif.done;
      if ((state_ff == DSC_READ) && tif.done &&
          (rdSync2_ff == rdSync3_ff)) begin
        rspData <= rdSync3_ff;
      end else if ((state_ff == DSC_READ) && tif.done) begin
        rspData <= rdSync2_ff;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_READ_STROBE_HIGH: assert property (@(posedge clk)
    disable iff (!arst_n) !outEnableN |-> writeStrobeN)
    else $error("strobe low during read");
  AST_NO_DRIVE_ON_READ: assert property (@(posedge clk)
    disable iff (!arst_n) !outEnableN |-> !byteLanesOe)
    else $error("data driven while memory output enabled");
  AST_SELECT_PAIR: assert property (@(posedge clk)
    disable iff (!arst_n) selectPrimaryN == !selectSecondaryHi)
    else $error("selects out of step");
  AST_WRITE_DATA_HELD: assert property (@(posedge clk)
    disable iff (!arst_n) !writeStrobeN
      |-> byteLanesOe && $stable(byteLanesOut))
    else $error("write data not held during strobe");
  AST_WRITE_SELECTED: assert property (@(posedge clk)
    disable iff (!arst_n) !writeStrobeN |-> !selectPrimaryN)
    else $error("strobe low while deselected");
  AST_STROBE_WITH_SEL: assert property (@(posedge clk)
    disable iff (!arst_n) $fell(selectPrimaryN) && isWrite_ff
      |-> !writeStrobeN && outEnableN)
    else $error("write start without strobe or with output on");
  AST_STANDBY_IDLE: assert property (@(posedge clk)
    disable iff (!arst_n) reqReady |-> selectPrimaryN && outEnableN)
    else $error("memory selected while idle");
  // nine = read phase plus the sync stretch
  AST_READ_RESP: assert property (@(posedge clk)
    disable iff (!arst_n) $fell(outEnableN) |-> ##9 (outEnableN && rspValid))
    else $error("read end without response");
  AST_TURN_GAP: assert property (@(posedge clk)
    disable iff (!arst_n) $rose(outEnableN) |-> !byteLanesOe[*2])
    else $error("data driven before memory output turned off");
  AST_SEL_GATES_READ: assert property (@(posedge clk)
    disable iff (!arst_n) selectPrimaryN |-> outEnableN)
    else $error("output enable active while deselected");
  AST_WRITE_END_TOGETHER: assert property (@(posedge clk)
    disable iff (!arst_n) $rose(writeStrobeN)
      |-> $rose(selectPrimaryN) && $fell(byteLanesOe))
    else $error("write end not aligned with select and drive");
  AST_ADDR_STABLE: assert property (@(posedge clk)
    disable iff (!arst_n) !selectPrimaryN |-> $stable(wordSelectLines))
    else $error("address moved while selected");
  AST_WRITE_WIDTH: assert property (@(posedge clk)
    disable iff (!arst_n) $fell(writeStrobeN) |-> !writeStrobeN[*5])
    else $error("write pulse too short");
endmodule

// file: rtl/dsc_pkg.sv
// package: constants and types for the dual-select static memory controller
// How it works
// - strobe held high through every read
// - write starts when last condition asserts
// - write ends first deassert; data held
// - never drive data while memory may drive
// - both selects share identical timing
package dsc_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int WORDS  = 8192;
  // access timing in ns, slowest speed grade; faster parts also fit
  localparam int T_CYCLE_NS  = 55;
  localparam int T_ACCESS_NS = 55;
  localparam int T_WP_NS     = 45;
  localparam int T_TURN_NS   = 15;
  localparam int CLK_NS      = 8;
  localparam logic [3:0] RD_CYC   = 4'((T_ACCESS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] WP_CYC   = 4'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] TURN_CYC = 4'((T_TURN_NS + CLK_NS - 1) / CLK_NS);
  // read data reaches the sequencer two flops after the pins
  localparam logic [3:0] SYNC_CYC = 4'h2;
  localparam logic [3:0] REC_CYC  =
    4'((T_CYCLE_NS - T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] CNT_ONE  = 4'h1;
  localparam logic [3:0] CNT_ZERO = 4'h0;

  typedef enum logic [4:0] {
    DSC_IDLE  = 5'h01,
    DSC_SETUP = 5'h02,
    DSC_READ  = 5'h04,
    DSC_WRITE = 5'h08,
    DSC_REC   = 5'h10
  } dsc_state_e;
endpackage

// file: rtl/dsc_timer_if.sv
// interface: load/expire link between sequencer and its cycle timer
`timescale 1ns/100ps
interface dsc_timer_if;
  logic       load;
  logic [3:0] count;
  logic       done;
  modport ctl (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface

// file: rtl/dsc_timer.sv
// module: down counter that times each phase of a memory access
`timescale 1ns/100ps
module dsc_timer
  import dsc_pkg::*;
(
  input  wire logic clk,
  input  wire logic arst_n,
  dsc_timer_if.tmr  tif
);
  logic [3:0] cnt_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= CNT_ZERO;
    end else if (tif.load) begin
      cnt_ff <= tif.count;
    end else if (cnt_ff != CNT_ZERO) begin
      cnt_ff <= cnt_ff - CNT_ONE;
    end
  end

  // done must not look at load: the sequencer derives load from done
  assign tif.done = (cnt_ff == CNT_ONE);
endmodule

// file: verification/dsc_sram_model.sv
// model: behavioural 8K x 8 dual-select static memory
`timescale 1ns/100ps
module dsc_sram_model
  import dsc_pkg::*;
(
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              selN,
  input  wire logic              selHi,
  input  wire logic              oeN,
  input  wire logic              weN,
  input  wire logic [DATA_W-1:0] hostData,
  input  wire logic              hostOe,
  output logic [DATA_W-1:0]      pinData,
  output logic                   memDrive
);
  logic [DATA_W-1:0] mem [WORDS];
  logic [DATA_W-1:0] lastVal = 8'h00;
  logic              active;
  logic              writing;
  // levels only, no clock anywhere
  assign active   = !selN && selHi;
  assign writing  = active && !weN;
  assign memDrive = active && weN && !oeN;
  // commit on whichever condition drops first
  always @(negedge writing) mem[addr] = hostData;
  always @* if (memDrive || hostOe)
    lastVal = memDrive ? mem[addr] : hostData;
  // released lines show the inverse, not a held value
  assign pinData = memDrive ? mem[addr] : hostOe ? hostData : ~lastVal;
endmodule

// file: verification/tb_dsc_sram_host.sv
// testbench: host controller against the behavioural memory model
`timescale 1ns/100ps
`define CHK(a, e) begin nTests++; if ((a) !== (e)) begin nMismatch++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module tb_dsc_sram_host import dsc_pkg::*;;
  logic              clk = 1'b0;
  logic              arst_n = 1'b0;
  logic              reqValid = 1'b0;
  logic              reqWrite = 1'b0;
  logic [ADDR_W-1:0] reqAddr = 13'h0000;
  logic [DATA_W-1:0] reqData = 8'h00;
  logic              reqReady, rspValid, selN, selHi, oeN, weN, hostOe;
  logic              memDrive;
  logic [DATA_W-1:0] rspData, pinData, hostData;
  logic [ADDR_W-1:0] addr;
  int                nMismatch = 0;
  int                nTests = 0;
  int                w;

  dsc_sram_host dut (.clk(clk), .arst_n(arst_n), .reqValid(reqValid),
    .reqReady(reqReady), .reqWrite(reqWrite), .reqAddr(reqAddr),
    .reqData(reqData), .rspValid(rspValid), .rspData(rspData),
    .wordSelectLines(addr), .selectPrimaryN(selN),
    .selectSecondaryHi(selHi), .outEnableN(oeN), .writeStrobeN(weN),
    .byteLanesIn(pinData), .byteLanesOut(hostData), .byteLanesOe(hostOe));
  dsc_sram_model mem (.addr(addr), .selN(selN), .selHi(selHi), .oeN(oeN),
    .weN(weN), .hostData(hostData), .hostOe(hostOe), .pinData(pinData),
    .memDrive(memDrive));

  initial forever #4 clk = ~clk;

  // ----------------------------------------
  // pin watch, every cycle
  // ----------------------------------------
  always @(negedge clk) if (arst_n) begin
    `CHK(selHi, ~selN)
    `CHK(oeN == 1'b0 && weN == 1'b0, 1'b0)
    `CHK(memDrive && hostOe, 1'b0)
    if (!weN) `CHK(memDrive, 1'b0)
    if (selN) `CHK(memDrive, 1'b0)
  end

  task automatic testDone();
    $display("tests %0d mismatches %0d", nTests, nMismatch);
    if (nMismatch == 0 && nTests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // held until taken; returns cycles spent refused
  task automatic issue(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, output int waits);
    reqValid <= 1'b1;
    reqWrite <= wr;
    reqAddr  <= a;
    reqData  <= d;
    waits = 0;
    @(negedge clk);
    while (reqReady !== 1'b1) begin
      waits++;
      if (waits > 40) begin nMismatch++; testDone(); end
      @(negedge clk);
    end
    @(posedge clk);
    reqValid <= 1'b0;
    // let an edge pass so the next call never re-raises in this step
    @(posedge clk);
  endtask

  task automatic readChk(input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] e);
    int k;
    issue(1'b0, a, 8'h00, w);
    for (k = 1; k < 20; k++) begin
      @(posedge clk);
      #1;
      if (rspValid === 1'b1) break;
    end
    `CHK(k, RD_CYC + SYNC_CYC)
    `CHK(rspData, e)
    @(posedge clk);
    #1;
    `CHK(rspValid, 1'b0)
    @(posedge clk);
  endtask

  task automatic scnReset();
    `CHK({selN, selHi, oeN, weN, hostOe}, 5'h16)
    `CHK(reqReady, 1'b1)
  endtask

  task automatic scnBounds();
    issue(1'b1, 13'h0000, 8'h5a, w);
    issue(1'b1, 13'h1fff, 8'ha5, w);
    issue(1'b1, 13'h0001, 8'hff, w);
    readChk(13'h0000, 8'h5a);
    readChk(13'h1fff, 8'ha5);
    readChk(13'h0001, 8'hff);
  endtask

  task automatic scnBackToBack();
    issue(1'b1, 13'h0a55, 8'h11, w);
    issue(1'b1, 13'h0a55, 8'h22, w);
    `CHK(w > 0, 1'b1)
    issue(1'b1, 13'h0a56, 8'h00, w);
    readChk(13'h0a55, 8'h22);
    readChk(13'h0a56, 8'h00);
    issue(1'b0, 13'h0a55, 8'h00, w);
    issue(1'b1, 13'h0a55, 8'h33, w);
    `CHK(w > 0, 1'b1)
    readChk(13'h0a55, 8'h33);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    nMismatch++;
    testDone();
  end

  initial begin
    repeat (12) @(posedge clk);
    scnReset();
    arst_n <= 1'b1;
    @(posedge clk);
    scnBounds();
    scnBackToBack();
    repeat (4) @(posedge clk);
    testDone();
  end
endmodule
